// File: shared/itr_pkg.sv
package itr_pkg;

  // Command set of the request write
  localparam logic [7:0] CMD_READ_ALL = 8'h21;
  localparam logic [7:0] CHK_READ_ALL = 8'hdf;

  // Fixed top bit of the target address and the management mode codes
  localparam logic       ADDR_TOP_BIT = 1'b1;
  localparam logic [1:0] MODE_I2C     = 2'h0;
  localparam logic [1:0] MODE_TIER1   = 2'h1;
  localparam logic [1:0] MODE_TIER2   = 2'h2;

  // Response layout
  localparam int         RESP_LEN     = 64;
  localparam logic [5:0] IDX_ECHO     = 6'h00;
  localparam logic [5:0] IDX_PAD      = 6'h01;
  localparam logic [5:0] IDX_TEMP     = 6'h02;
  localparam logic [5:0] IDX_RSVD     = 6'h03;
  localparam logic [5:0] IDX_FILL     = 6'h3e;
  localparam logic [5:0] IDX_CSUM     = 6'h3f;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [7:0] BYTE_FILL    = 8'haa;

  // Temperature range in degrees Celsius
  localparam logic signed [7:0] TEMP_MIN = -8'sd55;
  localparam logic signed [7:0] TEMP_MAX = 8'sd125;

  // Bit count at the end of a byte, reset values
  localparam logic [3:0] BITS_BYTE    = 4'h8;
  localparam logic [2:0] SYNC_RST     = 3'h7;
  localparam logic [5:0] SLOT_RST     = 6'h3f;

  typedef enum logic [2:0] {
    ITR_IDLE,
    ITR_ADDR,
    ITR_ACK,
    ITR_RX,
    ITR_TX,
    ITR_MACK
  } itr_state_t;

endpackage : itr_pkg

// File: logic/itr_resp_mem.sv
`timescale 1ns/1ps
`default_nettype none

module itr_resp_mem #(
  parameter int DW = 8,
  parameter int AW = 6
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [DW-1:0] wr_data_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [DW-1:0] rd_data_o
);

  logic [DW-1:0] mem_r [2**AW];
  logic [DW-1:0] rd_data_nxt;

  // Array write, no reset on storage
  always_ff @(posedge mclk_i)
  begin
    if (wr_en_i)
    begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read port
  always_comb
  begin
    rd_data_nxt = mem_r[rd_addr_i];
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_o <= '0;
    end
    else
    begin
      rd_data_o <= rd_data_nxt;
    end
  end

endmodule : itr_resp_mem

`default_nettype wire

// File: logic/itr_responder.sv
`timescale 1ns/1ps
`default_nettype none

module itr_responder (
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  input  wire logic [4:0]        slot_address_pins_n_i,
  input  wire logic              slot_parity_pin_n_i,
  input  wire logic [1:0]        mgmt_mode_i,
  input  wire logic signed [7:0] temp_c_i,
  input  wire logic              tel_we_i,
  input  wire logic [5:0]        tel_addr_i,
  input  wire logic [7:0]        tel_data_i,
  output logic                   resp_armed_o
);

  logic [2:0]         scl_s_r, sda_s_r;
  logic [5:0]         slot_s0_r, slot_s1_r, slot_s2_r, slot_r, slot_nxt;
  logic [1:0]         mode_s0_r, mode_s1_r, mode_s2_r, mode_r, mode_nxt;
  logic               scl_q_r, scl_q_nxt, scl_p_r, sda_q_r, sda_q_nxt, sda_p_r;
  logic               scl_rise, scl_fall, start_det, stop_det, load;
  itr_pkg::itr_state_t st_r, st_nxt;
  logic [7:0]         sh_r, sh_nxt, sum_r, sum_nxt, temp_r, temp_nxt, byte_sel, mem_q;
  logic [3:0]         cnt_r, cnt_nxt;
  logic [5:0]         idx_r, idx_nxt;
  logic [1:0]         wbyte_r, wbyte_nxt;
  logic               rw_r, rw_nxt, cmd_ok_r, cmd_ok_nxt, armed_r, armed_nxt;
  logic               mack_r, mack_nxt, oe_r, oe_nxt;
  logic [6:0]         my_addr;

  // Sign-magnitude temperature, clamped to the readable range
  function automatic logic [7:0] temp_code(input logic signed [7:0] t);
    logic signed [7:0] c;
    c = t;
    if (t < itr_pkg::TEMP_MIN)
      c = itr_pkg::TEMP_MIN;
    else if (t > itr_pkg::TEMP_MAX)
      c = itr_pkg::TEMP_MAX;
    temp_code = c[7] ? {1'b1, 7'(-c)} : {1'b0, c[6:0]};
  endfunction : temp_code

  // Three-stage synchronisers for pins from outside the clock domain
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scl_s_r   <= itr_pkg::SYNC_RST;
      sda_s_r   <= itr_pkg::SYNC_RST;
      slot_s0_r <= itr_pkg::SLOT_RST;
      slot_s1_r <= itr_pkg::SLOT_RST;
      slot_s2_r <= itr_pkg::SLOT_RST;
      mode_s0_r <= itr_pkg::MODE_I2C;
      mode_s1_r <= itr_pkg::MODE_I2C;
      mode_s2_r <= itr_pkg::MODE_I2C;
    end
    else
    begin
      scl_s_r   <= {scl_s_r[1:0], scl_i};
      sda_s_r   <= {sda_s_r[1:0], sda_i};
      slot_s0_r <= {slot_parity_pin_n_i, slot_address_pins_n_i};
      slot_s1_r <= slot_s0_r;
      slot_s2_r <= slot_s1_r;
      mode_s0_r <= mgmt_mode_i;
      mode_s1_r <= mode_s0_r;
      mode_s2_r <= mode_s1_r;
    end
  end

  // Accept a level once stages two and three agree
  always_comb
  begin
    scl_q_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_q_r;
    sda_q_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_q_r;
    slot_nxt  = (slot_s1_r == slot_s2_r) ? slot_s2_r : slot_r;
    mode_nxt  = (mode_s1_r == mode_s2_r) ? mode_s2_r : mode_r;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scl_q_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_q_r <= 1'b1;
      sda_p_r <= 1'b1;
      slot_r  <= itr_pkg::SLOT_RST;
      mode_r  <= itr_pkg::MODE_I2C;
    end
    else
    begin
      scl_q_r <= scl_q_nxt;
      scl_p_r <= scl_q_r;
      sda_q_r <= sda_q_nxt;
      sda_p_r <= sda_q_r;
      slot_r  <= slot_nxt;
      mode_r  <= mode_nxt;
    end
  end

  // Bus events and own address
  assign scl_rise  = scl_q_r & ~scl_p_r;
  assign scl_fall  = ~scl_q_r & scl_p_r;
  assign start_det = scl_q_r & scl_p_r & sda_p_r & ~sda_q_r;
  assign stop_det  = scl_q_r & scl_p_r & ~sda_p_r & sda_q_r;
  assign my_addr   = {itr_pkg::ADDR_TOP_BIT, ~slot_r};

  // Response bytes beyond the fixed fields
  itr_resp_mem #(
    .DW (8),
    .AW (6)
  ) itr_resp_mem_inst (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (tel_we_i),
    .wr_addr_i (tel_addr_i),
    .wr_data_i (tel_data_i),
    .rd_addr_i (idx_r),
    .rd_data_o (mem_q)
  );

  // Byte to send at the current index
  always_comb
  begin
    if (idx_r == itr_pkg::IDX_ECHO)
      byte_sel = itr_pkg::CMD_READ_ALL;
    else if (idx_r == itr_pkg::IDX_PAD || idx_r == itr_pkg::IDX_RSVD)
      byte_sel = itr_pkg::BYTE_ZERO;
    else if (idx_r == itr_pkg::IDX_TEMP)
      byte_sel = temp_r;
    else if (idx_r == itr_pkg::IDX_FILL)
      byte_sel = itr_pkg::BYTE_FILL;
    else if (idx_r == itr_pkg::IDX_CSUM)
      byte_sel = 8'(-sum_r);
    else
      byte_sel = mem_q;
  end

  assign load = scl_fall & ~start_det & ~stop_det &
                ((st_r == itr_pkg::ITR_ACK & rw_r) | (st_r == itr_pkg::ITR_MACK & mack_r));

  // Target protocol engine
  always_comb
  begin
    st_nxt     = st_r;
    sh_nxt     = sh_r;
    cnt_nxt    = cnt_r;
    rw_nxt     = rw_r;
    wbyte_nxt  = wbyte_r;
    cmd_ok_nxt = cmd_ok_r;
    armed_nxt  = armed_r;
    idx_nxt    = idx_r;
    sum_nxt    = sum_r;
    oe_nxt     = oe_r;
    mack_nxt   = mack_r;
    temp_nxt   = temp_r;
    if (stop_det)
    begin
      st_nxt = itr_pkg::ITR_IDLE;
      oe_nxt = 1'b0;
    end
    else if (start_det)
    begin
      st_nxt  = itr_pkg::ITR_ADDR;
      cnt_nxt = '0;
      oe_nxt  = 1'b0;
    end
    else if (load)
    begin
      sh_nxt  = byte_sel;
      oe_nxt  = ~byte_sel[7];
      sum_nxt = 8'(sum_r + byte_sel);
      cnt_nxt = 4'h1;
      st_nxt  = itr_pkg::ITR_TX;
    end
    else
    begin
      case (st_r)
        itr_pkg::ITR_ADDR, itr_pkg::ITR_RX:
        begin
          if (scl_rise)
          begin
            sh_nxt  = {sh_r[6:0], sda_q_r};
            cnt_nxt = 4'(cnt_r + 4'h1);
          end
          else if (scl_fall && cnt_r == itr_pkg::BITS_BYTE)
          begin
            st_nxt = itr_pkg::ITR_IDLE;
            if (st_r == itr_pkg::ITR_ADDR)
            begin
              // Only in I2C mode, only our address, reads only when armed
              if (sh_r[7:1] == my_addr && mode_r == itr_pkg::MODE_I2C && (!sh_r[0] || armed_r))
              begin
                st_nxt    = itr_pkg::ITR_ACK;
                oe_nxt    = 1'b1;
                rw_nxt    = sh_r[0];
                wbyte_nxt = '0;
                idx_nxt   = itr_pkg::IDX_ECHO;
                sum_nxt   = '0;
                if (!sh_r[0])
                begin
                  armed_nxt  = 1'b0;
                  cmd_ok_nxt = 1'b0;
                end
              end
            end
            else if (wbyte_r == 2'h0)
            begin
              // Any other command is left unacknowledged
              if (sh_r == itr_pkg::CMD_READ_ALL)
              begin
                st_nxt     = itr_pkg::ITR_ACK;
                oe_nxt     = 1'b1;
                cmd_ok_nxt = 1'b1;
                wbyte_nxt  = 2'h1;
              end
            end
            else if (wbyte_r == 2'h1)
            begin
              st_nxt    = itr_pkg::ITR_ACK;
              oe_nxt    = 1'b1;
              wbyte_nxt = 2'h2;
              if (cmd_ok_r && sh_r == itr_pkg::CHK_READ_ALL)
              begin
                armed_nxt = 1'b1;
                temp_nxt  = temp_code(temp_c_i);
              end
            end
          end
        end
        itr_pkg::ITR_ACK:
        begin
          if (scl_fall)
          begin
            oe_nxt  = 1'b0;
            cnt_nxt = '0;
            st_nxt  = itr_pkg::ITR_RX;
          end
        end
        itr_pkg::ITR_TX:
        begin
          if (scl_fall && cnt_r == itr_pkg::BITS_BYTE)
          begin
            oe_nxt = 1'b0;
            st_nxt = itr_pkg::ITR_MACK;
          end
          else if (scl_fall)
          begin
            sh_nxt  = {sh_r[6:0], 1'b0};
            oe_nxt  = ~sh_r[6];
            cnt_nxt = 4'(cnt_r + 4'h1);
          end
        end
        itr_pkg::ITR_MACK:
        begin
          if (scl_rise)
          begin
            mack_nxt = ~sda_q_r && idx_r != itr_pkg::IDX_CSUM;
            if (~sda_q_r && idx_r != itr_pkg::IDX_CSUM)
              idx_nxt = 6'(idx_r + 6'h1);
          end
          else if (scl_fall)
          begin
            st_nxt    = itr_pkg::ITR_IDLE;
            armed_nxt = 1'b0;
          end
        end
        default:
        begin
          st_nxt = st_r;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r     <= itr_pkg::ITR_IDLE;
      sh_r     <= '0;
      cnt_r    <= '0;
      rw_r     <= 1'b0;
      wbyte_r  <= '0;
      cmd_ok_r <= 1'b0;
      armed_r  <= 1'b0;
      idx_r    <= '0;
      sum_r    <= '0;
      oe_r     <= 1'b0;
      mack_r   <= 1'b0;
      temp_r   <= '0;
    end
    else
    begin
      st_r     <= st_nxt;
      sh_r     <= sh_nxt;
      cnt_r    <= cnt_nxt;
      rw_r     <= rw_nxt;
      wbyte_r  <= wbyte_nxt;
      cmd_ok_r <= cmd_ok_nxt;
      armed_r  <= armed_nxt;
      idx_r    <= idx_nxt;
      sum_r    <= sum_nxt;
      oe_r     <= oe_nxt;
      mack_r   <= mack_nxt;
      temp_r   <= temp_nxt;
    end
  end

  // Open-drain data: level always low, enable pulls
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sda_o <= 1'b0;
    else
      sda_o <= 1'b0;
  end

  assign sda_oe_o     = oe_r;
  assign resp_armed_o = armed_r;

  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  addr_match_a : assert property (st_r == itr_pkg::ITR_ADDR && st_nxt == itr_pkg::ITR_ACK
    |-> sh_r[7:1] == {1'b1, ~slot_r}) else $error("ack to foreign address");
  mode_gate_a : assert property (st_r == itr_pkg::ITR_ADDR && st_nxt == itr_pkg::ITR_ACK
    |-> mode_r == itr_pkg::MODE_I2C) else $error("ack outside i2c mode");
  cmd_ack_a : assert property (st_r == itr_pkg::ITR_RX && scl_fall && !start_det && !stop_det
    && cnt_r == itr_pkg::BITS_BYTE && wbyte_r == 2'h0 && sh_r == itr_pkg::CMD_READ_ALL
    |=> oe_r && st_r == itr_pkg::ITR_ACK) else $error("command not acknowledged");
  bad_cmd_nack_a : assert property (st_r == itr_pkg::ITR_RX && scl_fall && cnt_r == itr_pkg::BITS_BYTE
    && wbyte_r == 2'h0 && sh_r != itr_pkg::CMD_READ_ALL |=> !oe_r ##1 !armed_r) else $error("bad command acked");
  arm_cause_a : assert property ($rose(armed_r) |-> $past(sh_r) == itr_pkg::CHK_READ_ALL && cmd_ok_r
    && $past(wbyte_r) == 2'h1) else $error("armed without full request");
  temp_range_a : assert property (armed_r |-> (temp_r[7] ? temp_r[6:0] <= 7'd55
    : temp_r[6:0] <= 7'd125)) else $error("temperature code out of range");
  csum_zero_a : assert property (load && idx_r == itr_pkg::IDX_CSUM |=> sum_r == itr_pkg::BYTE_ZERO)
    else $error("response sum not zero");
  mack_release_a : assert property (st_r == itr_pkg::ITR_MACK |-> !oe_r)
    else $error("data driven during controller ack");

  full_read_c  : cover property (load && idx_r == itr_pkg::IDX_CSUM ##[1:1000] st_r == itr_pkg::ITR_IDLE);
  arm_c        : cover property ($rose(armed_r));
  bad_cmd_c    : cover property (st_r == itr_pkg::ITR_RX && scl_fall && cnt_r == itr_pkg::BITS_BYTE
                                 && sh_r != itr_pkg::CMD_READ_ALL);
  start_c      : cover property (st_r == itr_pkg::ITR_IDLE && start_det);

endmodule : itr_responder

`default_nettype wire

// File: test/itr_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none

// Controller side of the management bus, data pulled low through an enable
module itr_ctl_model #(
  parameter int HALF_NS = 2500
) (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  localparam int Q_NS = HALF_NS / 4;

  // Clock stands high and data is released outside frames
  initial
  begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  // Start or repeated start: data falls while clock high
  task automatic start_cond();
    #(Q_NS) sda_oe_o = 1'b0;
    #(HALF_NS - Q_NS) scl_o = 1'b1;
    #(HALF_NS) sda_oe_o = 1'b1;
    #(HALF_NS) scl_o = 1'b0;
  endtask : start_cond

  // Stop: data rises while clock high
  task automatic stop_cond();
    #(Q_NS) sda_oe_o = 1'b1;
    #(HALF_NS - Q_NS) scl_o = 1'b1;
    #(HALF_NS) sda_oe_o = 1'b0;
    #(HALF_NS);
  endtask : stop_cond

  // One bit: set in low phase, held through high phase, sampled mid high
  task automatic bit_xfer(input logic b, output logic r);
    #(Q_NS) sda_oe_o = ~b;
    #(HALF_NS - Q_NS) scl_o = 1'b1;
    #(HALF_NS / 2) r = sda_i;
    #(HALF_NS / 2) scl_o = 1'b0;
  endtask : bit_xfer

  // Byte written MSB first, ack is the target pulling data low
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = (r === 1'b0);
  endtask : wr_byte

  // Byte read MSB first, acked unless it is the last one
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(1'b1, d[i]);
    bit_xfer(last, r);
  endtask : rd_byte

endmodule : itr_ctl_model

`default_nettype wire

// File: test/itr_responder_tb.sv
`timescale 1ns/1ps
`default_nettype none

module itr_responder_tb;
  logic              mclk_i;
  logic              rst_n_i;
  logic              scl;
  logic              m_oe;
  logic              sda_o;
  logic              sda_oe_o;
  logic              par_n;
  logic              tel_we;
  logic              armed;
  logic [4:0]        ga_n;
  logic [1:0]        mode;
  logic signed [7:0] temp;
  logic [5:0]        tel_addr;
  logic [7:0]        tel_data;
  logic [7:0]        mem [64];
  int                err_total;
  int                checked;
  wire               sda_w;

  // Open-drain data line with pull-up
  assign sda_w = ~(m_oe | (sda_oe_o & ~sda_o));

  // Clock at 50 MHz
  always #10 mclk_i = ~mclk_i;

  itr_responder itr_responder_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .slot_address_pins_n_i(ga_n), .slot_parity_pin_n_i(par_n),
    .mgmt_mode_i(mode), .temp_c_i(temp), .tel_we_i(tel_we), .tel_addr_i(tel_addr),
    .tel_data_i(tel_data), .resp_armed_o(armed));

  // Half period of eight system clocks; the pin path needs five to answer
  itr_ctl_model #(
    .HALF_NS (160)
  ) itr_ctl_model_inst (.sda_i(sda_w), .scl_o(scl), .sda_oe_o(m_oe));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  function automatic logic [6:0] slot_addr();
    return {1'b1, ~par_n, ~ga_n};
  endfunction : slot_addr

  // Expected response around the stored bytes
  task automatic expect_resp(input int t);
    int         c;
    logic [7:0] s;
    c = (t < -55) ? -55 : (t > 125) ? 125 : t;
    mem[0] = 8'h21;
    mem[1] = 8'h00;
    mem[2] = (c < 0) ? {1'b1, 7'(-c)} : 8'(c);
    mem[3] = 8'h00;
    mem[62] = 8'haa;
    s = 8'h00;
    for (int i = 0; i < 63; i++)
      s = s + mem[i];
    mem[63] = 8'h00 - s;
  endtask : expect_resp

  // Request write: address, command, checksum, stop
  task automatic request(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] chk,
                         input logic [2:0] exp_ack, input logic exp_arm);
    logic [2:0] ack;
    ack = 3'h0;
    itr_ctl_model_inst.start_cond();
    itr_ctl_model_inst.wr_byte({a, 1'b0}, ack[2]);
    if (ack[2])
      itr_ctl_model_inst.wr_byte(cmd, ack[1]);
    if (ack[1])
      itr_ctl_model_inst.wr_byte(chk, ack[0]);
    itr_ctl_model_inst.stop_cond();
    check({5'h0, ack}, {5'h0, exp_ack});
    check({7'h0, armed}, {7'h0, exp_arm});
  endtask : request

  // Read of n bytes, the last one left without acknowledge
  task automatic read_resp(input logic [6:0] a, input int n, input logic exp_ack);
    logic       ack;
    logic [7:0] d;
    itr_ctl_model_inst.start_cond();
    itr_ctl_model_inst.wr_byte({a, 1'b1}, ack);
    check({7'h0, ack}, {7'h0, exp_ack});
    for (int i = 0; i < n && ack; i++)
    begin
      itr_ctl_model_inst.rd_byte(i == n - 1, d);
      check(d, mem[i]);
    end
    itr_ctl_model_inst.stop_cond();
    check({7'h0, armed}, 8'h00);
  endtask : read_resp

  // Back-to-back writes to every storage place
  task automatic fill_store();
    for (int i = 0; i < 64; i++)
    begin
      @(posedge mclk_i);
      #1;
      tel_we = 1'b1;
      tel_addr = 6'(i);
      tel_data = 8'(i * 13 + 5);
      mem[i] = 8'(i * 13 + 5);
    end
    @(posedge mclk_i);
    #1;
    tel_we = 1'b0;
  endtask : fill_store

  // Whole response, temperature clamped low and latched at arming
  task automatic t_full();
    expect_resp(-100);
    request(slot_addr(), 8'h21, 8'hdf, 3'h7, 1'b1);
    temp = 8'sd30;
    read_resp(slot_addr(), 64, 1'b1);
    $display("full read done");
  endtask : t_full

  // Unsupported command and bad checksum give nothing to read
  task automatic t_bad_cmd();
    request(slot_addr(), 8'h22, 8'hdf, 3'h4, 1'b0);
    read_resp(slot_addr(), 1, 1'b0);
    request(slot_addr(), 8'h21, 8'h00, 3'h7, 1'b0);
    $display("bad command done");
  endtask : t_bad_cmd

  // Target silent in both management tier modes
  task automatic t_mode();
    for (int m = 1; m < 3; m++)
    begin
      @(posedge mclk_i);
      #1;
      mode = 2'(m);
      repeat (4) @(posedge mclk_i);
      #1;
      request(slot_addr(), 8'h21, 8'hdf, 3'h0, 1'b0);
    end
    @(posedge mclk_i);
    #1;
    mode = 2'h0;
    $display("mode done");
  endtask : t_mode

  // New slot pins move the address; a read ended early by a not-acknowledged byte disarms
  task automatic t_slot_temp();
    logic [6:0] old;
    int         tv [2] = '{127, -5};
    old = slot_addr();
    @(posedge mclk_i);
    #1;
    ga_n = 5'h09;
    par_n = 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
    request(old, 8'h21, 8'hdf, 3'h0, 1'b0);
    foreach (tv[k])
    begin
      temp = 8'(tv[k]);
      expect_resp(tv[k]);
      request(slot_addr(), 8'h21, 8'hdf, 3'h7, 1'b1);
      read_resp(slot_addr(), 3, 1'b1);
      read_resp(slot_addr(), 1, 1'b0);
    end
    $display("slot and temperature done");
  endtask : t_slot_temp

  // Reset, then the scenarios in turn
  initial
  begin
    mclk_i = 1'b0;
    rst_n_i = 1'b0;
    ga_n = 5'h16;
    par_n = 1'b0;
    mode = 2'h0;
    temp = -8'sd100;
    tel_we = 1'b0;
    tel_addr = 6'h00;
    tel_data = 8'h00;
    err_total = 0;
    checked = 0;
    repeat (8) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    fill_store();
    t_full();
    t_bad_cmd();
    t_mode();
    t_slot_temp();
    test_done();
  end

  // Hang guard, about twice the expected run
  initial
  begin
    #600_000;
    err_total++;
    test_done();
  end

endmodule : itr_responder_tb

`default_nettype wire
